//--- fail_output_and_alt_gpio_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module fail_output_and_alt_gpio_tb_top;
  import fo_pkg::*;
  localparam int BLINK = 40;
  localparam int DIM = 80;
  logic clk_sys;
  logic reset_n;
  logic regWrite;
  logic regRead;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic [7:0] rdVal;
  fo_mode_t opMode;
  fo_fault_t faults;
  fo_wd_t watchdog;
  logic failSafeRequest;
  logic devSenseLevel;
  logic staticFailOut;
  logic staticFailOeN;
  logic staticLevel;
  logic [1:0] altLevel;
  logic [1:0] extPullLow;
  logic [1:0] altPinOut;
  logic [1:0] altPinOeN;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  int lows;

  fo_fail_outputs #(.BLINK_CYCLES(BLINK), .DIM_CYCLES(DIM)) i_fo_fail_outputs (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .opMode(opMode),
    .faults(faults), .watchdog(watchdog), .failSafeRequest(failSafeRequest),
    .devSenseLevel(devSenseLevel), .staticFailOut(staticFailOut), .staticFailOeN(staticFailOeN),
    .altPinIn(altLevel), .altPinOut(altPinOut), .altPinOeN(altPinOeN)
  );

  fo_lamp_model i_fo_lamp_model (
    .staticFailOeN(staticFailOeN), .altPinOut(altPinOut), .altPinOeN(altPinOeN),
    .extPullLow(extPullLow), .staticLevel(staticLevel), .altLevel(altLevel)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    idle(2);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    rdVal = regRdData;
  endtask : rd

  task automatic pulse(input fo_fault_t f);
    @(posedge clk_sys);
    faults <= f;
    @(posedge clk_sys);
    faults <= '0;
  endtask : pulse

  task automatic wdp(input logic fail, input logic ok);
    @(posedge clk_sys);
    watchdog.failEvent <= fail;
    watchdog.triggerOk <= ok;
    @(posedge clk_sys);
    watchdog.failEvent <= 1'b0;
    watchdog.triggerOk <= 1'b0;
    idle(1);
  endtask : wdp

  task automatic count_low(input int idx, input int n);
    lows = 0;
    repeat (n)
    begin
      @(negedge clk_sys);
      if (altPinOeN[idx] === 1'b0)
        lows++;
    end
  endtask : count_low

  task automatic t_reset();
    rd(ADDR_CTRL);
    `CHK(rdVal, CTRL_RESET)
    rd(ADDR_PINCFG);
    `CHK(rdVal, PINCFG_RESET)
    rd(8'h20);
    `CHK(rdVal, 8'h00)
    `CHK(staticFailOeN, 1'b1)
    `CHK(altPinOeN, 2'b11)
  endtask : t_reset

  // Applies a level fault, checks activation, refused and accepted clears.
  task automatic trip(input fo_fault_t f, input logic act);
    @(posedge clk_sys);
    faults <= f;
    idle(1);
    `CHK(staticFailOeN, !act)
    `CHK(staticFailOut, 1'b0)
    `CHK(staticLevel, !act)
    `CHK(failSafeRequest, act)
    idle(1);
    `CHK(failSafeRequest, 1'b0)
    rd(ADDR_DEVSTAT);
    `CHK(rdVal[DEVSTAT_FAIL_BIT], act)
    wr(ADDR_DEVSTAT, 8'h01);
    `CHK(staticFailOeN, !act)
    @(posedge clk_sys);
    faults <= '0;
    wr(ADDR_DEVSTAT, 8'h01);
    `CHK(staticFailOeN, 1'b1)
  endtask : trip

  task automatic t_undervoltage();
    repeat (3) pulse(5'b00010);
    pulse(5'b00001);
    repeat (3) pulse(5'b00010);
    idle(3);
    `CHK(staticFailOeN, 1'b1)
    pulse(5'b00010);
    idle(2);
    `CHK(staticFailOeN, 1'b0)
    // The first clear drops the latched undervoltage count, the second clears the flag.
    wr(ADDR_DEVSTAT, 8'h01);
    `CHK(staticFailOeN, 1'b0)
    wr(ADDR_DEVSTAT, 8'h01);
    `CHK(staticFailOeN, 1'b1)
  endtask : t_undervoltage

  task automatic t_watchdog();
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk_sys);
      watchdog.cfgSel <= c[1:0];
      wdp(1'b1, 1'b0);
      `CHK(staticFailOeN, c != 0)
      wdp(1'b1, 1'b0);
      `CHK(staticFailOeN, 1'b0)
      wr(ADDR_DEVSTAT, 8'h01);
      `CHK(staticFailOeN, 1'b0)
      wdp(1'b0, 1'b1);
      wr(ADDR_DEVSTAT, 8'h01);
      `CHK(staticFailOeN, 1'b1)
    end
    wdp(1'b1, 1'b0);
    rd(ADDR_DEVSTAT);
    `CHK(rdVal, 8'h02)
    @(posedge clk_sys);
    opMode <= MODE_SLEEP;
    @(posedge clk_sys);
    opMode <= MODE_NORMAL;
    rd(ADDR_DEVSTAT);
    `CHK(rdVal, 8'h00)
  endtask : t_watchdog

  task automatic t_waveforms();
    int divs[4];
    divs = '{DUTY_DIV_20, DUTY_DIV_10, DUTY_DIV_5, DUTY_DIV_2P5};
    for (int d = 0; d < 4; d++)
    begin
      wr(ADDR_CTRL, 8'(d << CTRL_DUTY_LSB) | 8'h01);
      `CHK(staticFailOeN, 1'b0)
      count_low(1, DIM);
      `CHK(lows, DIM / divs[d])
      count_low(0, BLINK);
      `CHK(lows, BLINK / 2)
    end
    wr(ADDR_CTRL, CTRL_RESET);
    `CHK(staticFailOeN, 1'b1)
    `CHK(altPinOeN, 2'b11)
  endtask : t_waveforms

  task automatic t_pins();
    wr(ADDR_PINCFG, 8'hcb);
    idle(4);
    `CHK(altPinOeN, 2'b00)
    `CHK(altPinOut, 2'b10)
    rd(ADDR_LEVEL);
    `CHK(rdVal[1:0], 2'b10)
    `CHK(devSenseLevel, 1'b1)
    @(posedge clk_sys);
    opMode <= MODE_RESTART;
    idle(2);
    `CHK(altPinOeN, 2'b11)
    @(posedge clk_sys);
    opMode <= MODE_NORMAL;
    idle(2);
    `CHK(altPinOeN, 2'b00)
    @(posedge clk_sys);
    opMode <= MODE_STOP;
    wr(ADDR_PINCFG, PINCFG_RESET);
    rd(ADDR_PINCFG);
    `CHK(rdVal, 8'hcb)
    @(posedge clk_sys);
    opMode <= MODE_NORMAL;
    wr(ADDR_PINCFG, PINCFG_RESET);
    rd(ADDR_PINCFG);
    `CHK(rdVal, PINCFG_RESET)
  endtask : t_pins

  // Pin zero as wake input, pin one off; both lines pulled low from outside.
  task automatic t_wake();
    wr(ADDR_PINCFG, 8'h12);
    `CHK(altPinOeN, 2'b11)
    @(posedge clk_sys);
    extPullLow <= 2'b11;
    idle(1500);
    rd(ADDR_WAKESTAT);
    `CHK(rdVal, 8'h00)
    idle(200);
    rd(ADDR_WAKESTAT);
    `CHK(rdVal, 8'h01)
    rd(ADDR_LEVEL);
    `CHK(rdVal, 8'h00)
    `CHK(devSenseLevel, 1'b0)
    wr(ADDR_WAKESTAT, 8'h01);
    rd(ADDR_WAKESTAT);
    `CHK(rdVal, 8'h00)
    @(posedge clk_sys);
    opMode <= MODE_FAILSAFE;
    extPullLow <= 2'b00;
    idle(1700);
    rd(ADDR_WAKESTAT);
    `CHK(rdVal, 8'h00)
    @(posedge clk_sys);
    opMode <= MODE_NORMAL;
    wr(ADDR_PINCFG, PINCFG_RESET);
  endtask : t_wake

  initial
  begin
    reset_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    opMode = MODE_NORMAL;
    faults = '0;
    watchdog = '0;
    extPullLow = 2'b00;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    trip(5'b10000, 1'b1);
    trip(5'b01000, 1'b1);
    trip(5'b00100, 1'b0);
    wr(ADDR_CTRL, 8'h02);
    trip(5'b00100, 1'b1);
    wr(ADDR_CTRL, CTRL_RESET);
    t_undervoltage();
    t_watchdog();
    t_waveforms();
    t_pins();
    t_wake();
    tally_and_finish();
  end
endmodule : fail_output_and_alt_gpio_tb_top

//--- fo_fail_outputs.sv
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
// Behaviour
// - Three open-drain active-low fail outputs share one failure logic.
// - Watchdog failure trips on first (config 1) or second (configs 2 to 4) failure.
// - Hard thermal shutdown and main regulator short trip the fail outputs.
// - Main overvoltage trips only while the overvoltage-reset enable is set.
// - Four consecutive main undervoltage events trip the fail outputs.
// - Fail-safe entry is requested on activation, watchdog depending on config.
// - Activation by failure sets the failure flag in device status.
// - Test-force bit drives outputs regardless of flags; clearing it releases them if the failure flag is clear.
// - Outputs release only when no condition remains and software clears flag.
// - Watchdog failure bits clear on sleep, non-watchdog fail-safe, stop disable.
// - Watchdog config 2 does not trip on the first watchdog failure; it only counts it.
// - All outputs switch on together; the static output stays low throughout.
// - Blinking output toggles at 1.25 Hz, 50 percent duty.
// - Dimming output is a 100 Hz PWM, 20 percent by default.
// - Dimming duty selectable 20, 10, 5, 2.5 percent; 20 after reset.
// - Pin config reassigns the two pins to off, wake, low-side, high-side.
// - Wake-configured pins filter like wake pins and log to second wake status.
// - Switch-configured pins drive 10 mA loads, limited, with no diagnostics.
// - Level status shows live pin levels in normal and stop; pin two shared.
// - Config changes only in normal; wake off in fail-safe; switches off in restart.
// - After restart the configured function resumes; failure activation persists.
module fo_fail_outputs
  import fo_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYCLES_DEF,
  parameter int DIM_CYCLES = DIM_CYCLES_DEF
)(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Status to and from neighbouring blocks.
  input wire fo_mode_t opMode,
  input wire fo_fault_t faults,
  input wire fo_wd_t watchdog,
  output logic failSafeRequest,
  output logic devSenseLevel,
  // Static fail output, open drain.
  output logic staticFailOut,
  output logic staticFailOeN,
  // Blinking and dimming pins, index 0 blinking, index 1 dimming.
  input wire logic [1:0] altPinIn,
  output logic [1:0] altPinOut,
  output logic [1:0] altPinOeN
);

  logic [7:0] ctrl_q;
  logic [7:0] pinCfg_q;
  logic failFlag_q;
  logic [1:0] wdCnt_q;
  logic [2:0] uvCnt_q;
  logic [1:0] wakeStat_q;
  logic [1:0] level_q;
  logic [7:0] rdData_q;
  logic [31:0] blinkCnt_q;
  logic [31:0] dimCnt_q;
  logic failActivePrev_q;
  logic [1:0] pinSync1_q;
  logic [1:0] pinSync2_q;
  logic [1:0] wakeEvent;

  wire wrCtrl = regWrite && (regAddr == ADDR_CTRL);
  wire wrPinCfg = regWrite && (regAddr == ADDR_PINCFG) && (opMode == MODE_NORMAL);
  wire wrDevStat = regWrite && (regAddr == ADDR_DEVSTAT);
  wire wrWakeStat = regWrite && (regAddr == ADDR_WAKESTAT);

  wire testForce = ctrl_q[CTRL_FORCE_BIT];
  wire ovResetEn = ctrl_q[CTRL_OVEN_BIT];
  wire [1:0] dutySel = ctrl_q[CTRL_DUTY_LSB +: 2];

  // Level conditions that keep the outputs latched on.
  wire uvTrip = (uvCnt_q == UV_TRIP_COUNT);
  wire condPresent = faults.thermalShutdownHard || faults.mainShortToGround
                     || (faults.mainOvervoltage && ovResetEn) || uvTrip;

  // A watchdog failure trips at once only for config 1; configs 2 to 4 need a second.
  wire wdTrip = watchdog.failEvent
                && ((watchdog.cfgSel == WD_CFG_ONE) || (wdCnt_q != 2'h0));
  wire nonWdEntry = condPresent && !failFlag_q;
  wire failTrip = condPresent || wdTrip;

  // Software clear is honoured only with nothing left asserting a failure.
  wire clearReq = wrDevStat && regWrData[DEVSTAT_FAIL_BIT];
  wire clearOk = clearReq && !condPresent && (wdCnt_q == 2'h0);

  wire wdClear = watchdog.triggerOk || (opMode == MODE_SLEEP) || nonWdEntry
                 || ((opMode == MODE_STOP) && watchdog.disabledInStop);

  wire failActive = failFlag_q || testForce;
  wire failRise = failActive && !failActivePrev_q;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= CTRL_RESET;
      pinCfg_q <= PINCFG_RESET;
    end
    else
    begin
      if (wrCtrl)
        ctrl_q <= regWrData;
      if (wrPinCfg)
        pinCfg_q <= regWrData;
    end
  end

  // Setting wins over clearing for the failure flag.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      failFlag_q <= 1'b0;
    else if (failTrip)
      failFlag_q <= 1'b1;
    else if (clearOk)
      failFlag_q <= 1'b0;
  end

  // Watchdog failure count saturates at two; a new failure beats a clear.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wdCnt_q <= 2'h0;
    else if (watchdog.failEvent)
      wdCnt_q <= (wdCnt_q == 2'h2) ? wdCnt_q : wdCnt_q + 2'h1;
    else if (wdClear)
      wdCnt_q <= 2'h0;
  end

  // Undervoltage events count up to four; a break resets a lower count, four holds until a software clear.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      uvCnt_q <= 3'h0;
    else if (faults.mainUndervoltageEvent && !uvTrip)
      uvCnt_q <= uvCnt_q + 3'h1;
    else if (faults.mainUndervoltageBreak && !uvTrip)
      uvCnt_q <= 3'h0;
    else if (uvTrip && clearReq && !faults.thermalShutdownHard && !faults.mainShortToGround)
      uvCnt_q <= 3'h0;
  end

  // Fail-safe request on a new non-watchdog trip, or a watchdog trip in configs 1 and 2.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      failSafeRequest <= 1'b0;
    else
      failSafeRequest <= nonWdEntry || (wdTrip && !watchdog.cfgSel[1]);
  end

  // Waveform counters run free and restart when the outputs come on.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      blinkCnt_q <= 32'h0;
      dimCnt_q <= 32'h0;
      failActivePrev_q <= 1'b0;
    end
    else
    begin
      failActivePrev_q <= failActive;
      if (failRise || (blinkCnt_q == 32'(BLINK_CYCLES - 1)))
        blinkCnt_q <= 32'h0;
      else
        blinkCnt_q <= blinkCnt_q + 32'h1;
      if (failRise || (dimCnt_q == 32'(DIM_CYCLES - 1)))
        dimCnt_q <= 32'h0;
      else
        dimCnt_q <= dimCnt_q + 32'h1;
    end
  end

  wire blinkLow = blinkCnt_q < 32'(BLINK_CYCLES / 2);
  wire [31:0] dimOnCycles = (dutySel == 2'h0) ? 32'(DIM_CYCLES / DUTY_DIV_20) :
                            (dutySel == 2'h1) ? 32'(DIM_CYCLES / DUTY_DIV_10) :
                            (dutySel == 2'h2) ? 32'(DIM_CYCLES / DUTY_DIV_5) :
                            32'(DIM_CYCLES / DUTY_DIV_2P5);
  wire dimLow = dimCnt_q < dimOnCycles;
  wire [1:0] waveLow = {dimLow, blinkLow};

  // The static output is open drain and only ever pulls low.
  assign staticFailOut = 1'b0;
  assign staticFailOeN = !failActive;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinSync1_q <= 2'h0;
      pinSync2_q <= 2'h0;
    end
    else
    begin
      pinSync1_q <= altPinIn;
      pinSync2_q <= pinSync1_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : gPin
      wire [2:0] cfg = pinCfg_q[gi * PINCFG_FIELD_W +: 3];
      wire swOn = pinCfg_q[gi * PINCFG_FIELD_W + 3];
      wire swAllowed = (opMode != MODE_RESTART) && (opMode != MODE_FAILSAFE);
      wire wakeCapable = (cfg == PIN_WAKE) && (opMode != MODE_FAILSAFE);
      wire driveLow = ((cfg == PIN_FAIL) && failActive && waveLow[gi])
                      || ((cfg == PIN_LOWSIDE) && swOn && swAllowed);
      wire driveHigh = (cfg == PIN_HIGHSIDE) && swOn && swAllowed;
      logic filtLvl_q;
      logic [11:0] filtCnt_q;

      // Static-sense wake filter: a change must hold for the filter time.
      // The filter starts at the pulled-up idle level, so leaving reset gives no false wake.
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          filtLvl_q <= 1'b1;
          filtCnt_q <= 12'h0;
        end
        else if (pinSync2_q[gi] == filtLvl_q)
          filtCnt_q <= 12'h0;
        else if (filtCnt_q == WAKE_FILTER_CYCLES - 12'h1)
        begin
          filtLvl_q <= pinSync2_q[gi];
          filtCnt_q <= 12'h0;
        end
        else
          filtCnt_q <= filtCnt_q + 12'h1;
      end

      assign wakeEvent[gi] = wakeCapable && (pinSync2_q[gi] != filtLvl_q)
                             && (filtCnt_q == WAKE_FILTER_CYCLES - 12'h1);
      assign altPinOut[gi] = driveHigh;
      assign altPinOeN[gi] = !(driveLow || driveHigh);
    end
  endgenerate

  // Wake status is write-one-to-clear; a new event wins over the clear.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wakeStat_q <= 2'h0;
    else
      wakeStat_q <= wakeEvent | (wakeStat_q & ~(wrWakeStat ? regWrData[1:0] : 2'h0));
  end

  // Live pin levels are tracked in normal and stop and held otherwise.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      level_q <= 2'h0;
    else if ((opMode == MODE_NORMAL) || (opMode == MODE_STOP))
      level_q <= pinSync2_q;
  end

  assign devSenseLevel = level_q[1];

  wire [7:0] rdMux = (regAddr == ADDR_CTRL) ? ctrl_q :
                     (regAddr == ADDR_PINCFG) ? pinCfg_q :
                     (regAddr == ADDR_DEVSTAT) ? {5'h0, wdCnt_q, failFlag_q} :
                     (regAddr == ADDR_WAKESTAT) ? {6'h0, wakeStat_q} :
                     (regAddr == ADDR_LEVEL) ? {6'h0, level_q} : 8'h00;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rdData_q <= 8'h00;
    else if (regRead)
      rdData_q <= rdMux;
    else
      rdData_q <= 8'h00;
  end

  assign regRdData = rdData_q;

  chk_thermal_trips: assert property (@(posedge clk_sys) disable iff (!reset_n)
    faults.thermalShutdownHard |=> failFlag_q && !staticFailOeN)
    else $error("Thermal shutdown did not activate the fail outputs.");

  chk_ov_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!failFlag_q && !wdTrip && !faults.thermalShutdownHard && !faults.mainShortToGround
     && !uvTrip && !ovResetEn && faults.mainOvervoltage) |=> !failFlag_q)
    else $error("Overvoltage tripped while its enable was clear.");

  chk_uv_fourth: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (faults.mainUndervoltageEvent && uvCnt_q == 3'h3) |=> ##1 failFlag_q)
    else $error("Fourth undervoltage event did not set the failure flag.");

  chk_flag_cause: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(failFlag_q) |-> $past(condPresent || wdTrip))
    else $error("Failure flag rose without a cause.");

  chk_force_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wrCtrl && regWrData[CTRL_FORCE_BIT]) |=> !staticFailOeN)
    else $error("Test force did not activate the static output.");

  chk_clear_blocked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (failFlag_q && clearReq && condPresent) |=> failFlag_q)
    else $error("Failure flag cleared while a condition was present.");

  chk_cfg2_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (watchdog.failEvent && watchdog.cfgSel == WD_CFG_TWO && wdCnt_q == 2'h0
     && !failFlag_q && !condPresent) |=> !failFlag_q)
    else $error("First watchdog failure in config 2 set the failure flag.");

  chk_sleep_wdclr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (opMode == MODE_SLEEP && !watchdog.failEvent) |=> wdCnt_q == 2'h0)
    else $error("Watchdog failure bits survived sleep entry.");

  chk_wave_restart: assert property (@(posedge clk_sys) disable iff (!reset_n)
    failRise |=> (dimCnt_q == 32'h0) && (blinkCnt_q == 32'h0))
    else $error("Waveform counters did not restart on activation.");

  chk_cfg_frozen: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (opMode != MODE_NORMAL) |=> $stable(pinCfg_q))
    else $error("Pin configuration changed outside normal mode.");

  chk_switch_restart: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (opMode == MODE_RESTART && pinCfg_q[2:0] != PIN_FAIL) |-> altPinOeN[0])
    else $error("Switch stayed on in restart.");

  chk_wake_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wakeEvent != 2'h0) |=> ((wakeStat_q & $past(wakeEvent)) == $past(wakeEvent)))
    else $error("Wake event was not recorded in wake status.");

  chk_wake_failsafe: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (opMode == MODE_FAILSAFE) |=> ((wakeStat_q & ~$past(wakeStat_q)) == 2'h0))
    else $error("Wake status rose in fail-safe mode.");

endmodule : fo_fail_outputs

//--- fo_lamp_model.sv
`timescale 1ns/100ps
module fo_lamp_model
  import fo_pkg::*;
(
  // Pin drivers of the block.
  input wire logic staticFailOeN,
  input wire logic [1:0] altPinOut,
  input wire logic [1:0] altPinOeN,
  // Far-side switches that pull each alternate line low.
  input wire logic [1:0] extPullLow,
  // Resolved line levels.
  output logic staticLevel,
  output logic [1:0] altLevel
);
  // Lamp lines are pulled up, so a released line reads high unless extPullLow pulls it low.
  assign staticLevel = staticFailOeN ? 1'b1 : 1'b0;
  assign altLevel[0] = extPullLow[0] ? 1'b0 : (altPinOeN[0] ? 1'b1 : altPinOut[0]);
  assign altLevel[1] = extPullLow[1] ? 1'b0 : (altPinOeN[1] ? 1'b1 : altPinOut[1]);
endmodule : fo_lamp_model

//--- fo_pkg.sv
package fo_pkg;

  // Operating modes reported by the mode control block.
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } fo_mode_t;

  // Failure sources from the regulator and thermal supervisors.
  typedef struct packed {
    logic thermalShutdownHard;
    logic mainShortToGround;
    logic mainOvervoltage;
    logic mainUndervoltageEvent;
    logic mainUndervoltageBreak;
  } fo_fault_t;

  // Watchdog status from the watchdog block.
  typedef struct packed {
    logic failEvent;
    logic triggerOk;
    logic disabledInStop;
    logic [1:0] cfgSel;
  } fo_wd_t;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PINCFG = 8'h04;
  localparam logic [7:0] ADDR_DEVSTAT = 8'h08;
  localparam logic [7:0] ADDR_WAKESTAT = 8'h0c;
  localparam logic [7:0] ADDR_LEVEL = 8'h10;

  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_OVEN_BIT = 1;
  localparam int CTRL_DUTY_LSB = 2;
  localparam int DEVSTAT_FAIL_BIT = 0;
  localparam int DEVSTAT_WD_LSB = 1;
  localparam int PINCFG_FIELD_W = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PINCFG_RESET = 8'h00;

  localparam logic [2:0] PIN_FAIL = 3'h0;
  localparam logic [2:0] PIN_OFF = 3'h1;
  localparam logic [2:0] PIN_WAKE = 3'h2;
  localparam logic [2:0] PIN_LOWSIDE = 3'h3;
  localparam logic [2:0] PIN_HIGHSIDE = 3'h4;

  localparam logic [1:0] WD_CFG_ONE = 2'h0;
  localparam logic [1:0] WD_CFG_TWO = 2'h1;
  localparam logic [2:0] UV_TRIP_COUNT = 3'h4;

  localparam int CLK_MHZ = 100;
  localparam int BLINK_PERIOD_MS = 800;
  localparam int DIM_PERIOD_MS = 10;
  localparam int WAKE_FILTER_US = 16;
  localparam int BLINK_CYCLES_DEF = BLINK_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int DIM_CYCLES_DEF = DIM_PERIOD_MS * 1000 * CLK_MHZ;
  localparam logic [11:0] WAKE_FILTER_CYCLES = 12'(WAKE_FILTER_US * CLK_MHZ);
  localparam int DUTY_DIV_20 = 5;
  localparam int DUTY_DIV_10 = 10;
  localparam int DUTY_DIV_5 = 20;
  localparam int DUTY_DIV_2P5 = 40;

endpackage : fo_pkg
